// >>> pot_status_pkg.sv
// Constants shared by the potentiometer status and write-protect logic
package pot_status_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 9;
  localparam int unsigned OP_W     = 2;
  localparam int unsigned HV_SEL_W = 2;

  // Location map
  localparam logic [ADDR_W-1:0] ADDR_VWIPER0  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_VWIPER1  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_NVWIPER0 = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_NVWIPER1 = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_TERMINAL_CONTROL     = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATE    = 4'h5;

  // Serial command operations
  localparam logic [OP_W-1:0] OP_WRITE = 2'h0;
  localparam logic [OP_W-1:0] OP_INC   = 2'h1;
  localparam logic [OP_W-1:0] OP_DEC   = 2'h2;
  localparam logic [OP_W-1:0] OP_READ  = 2'h3;

  // High-voltage programming targets
  localparam logic [HV_SEL_W-1:0] HV_SEL_PROTECT = 2'h0;
  localparam logic [HV_SEL_W-1:0] HV_SEL_LOCK0   = 2'h1;
  localparam logic [HV_SEL_W-1:0] HV_SEL_LOCK1   = 2'h2;

  // device_state_word field layout
  localparam int unsigned    ST_RSVD_LSB   = 4;
  localparam logic [4:0]     ST_RSVD_ONES  = 5'h1F;
  localparam int unsigned    ST_ACTIVE_BIT = 3;
  localparam int unsigned    ST_LOCK1_BIT  = 2;
  localparam int unsigned    ST_LOCK0_BIT  = 1;
  localparam int unsigned    ST_PROT_BIT   = 0;

  // terminal_control write mask layout
  localparam int unsigned      TERMINAL_CONTROL_CH1_LSB = 4;
  localparam int unsigned      TERMINAL_CONTROL_CH0_LSB = 0;
  localparam logic [3:0]       TERMINAL_CONTROL_CH_ALL  = 4'hF;
  localparam logic [3:0]       TERMINAL_CONTROL_CH_NONE = 4'h0;

  // Reset values
  localparam logic              RST_LOCK    = 1'b0;
  localparam logic              RST_PROTECT = 1'b0;
  localparam logic [DATA_W-1:0] RST_DATA    = 9'h000;

  // Timing
  localparam int unsigned CLK_PERIOD_PS       = 4000;
  localparam int unsigned NV_WRITE_TIME_US    = 5000;
  // Scaled per microsecond so the product stays inside 32 bits
  localparam int unsigned NV_WRITE_CYCLES_DEF =
    NV_WRITE_TIME_US * ((1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

endpackage : pot_status_pkg

// >>> nv_write_timer.sv
// Non-volatile write cycle timer
`timescale 1ns/10ps
module nv_write_timer #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      last_o
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             busy_ff;
  logic             nxt_busy;

  // Final busy cycle, so the owner can retire the write on the same edge
  assign last_o = busy_ff && (cnt_ff == CNT_ONE);
  assign busy_o = busy_ff;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    if (busy_ff) begin
      nxt_cnt = cnt_ff - CNT_ONE;
      if (last_o) begin
        nxt_busy = 1'b0;
      end
    end else if (start_i) begin
      nxt_cnt  = CNT_LOAD;
      nxt_busy = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
    end else if (en_i) begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

endmodule : nv_write_timer

// >>> pot_status_protect_logic.sv
// Status word and write gating for a dual-channel digital potentiometer
//
// Overview of operation
// - The five upper bits of the nine-bit status word always read as one.
// - The write-active bit reads one for the whole of a non-volatile write cycle.
// - The write-active bit reads zero whenever no non-volatile write cycle runs.
// - During a non-volatile write only the two volatile wipers, terminal control and status are served.
// - Channel 1 lock refuses writes to both wiper-1 locations and the four channel-1 terminal bits.
// - Channel 0 lock refuses writes to both wiper-0 locations and the four channel-0 terminal bits.
// - Lock bits load from their stored copies after reset and then follow the latest programming.
// - Ordinary serial writes to the status word are accepted but change nothing.
// - Effective protect blocks every serial write to non-volatile memory; high-voltage programming is still accepted.
// - Volatile wipers stay writable, incrementable and decrementable under protect; terminal control stays writable only.
// - Effective protect is the protect pin active OR the stored protect bit.
// - The status word sits at location five of the sixteen-location map.
// - A serial read of location five returns the current status bits.
`timescale 1ns/10ps
module pot_status_protect_logic #(
  parameter int unsigned NV_WRITE_CYCLES = pot_status_pkg::NV_WRITE_CYCLES_DEF
) (
  input  wire logic                                  CLK_SYS_I,
  input  wire logic                                  SYS_RST_I,
  input  wire logic                                  CLK_EN_I,
  input  wire logic                                  CMD_VALID_I,
  input  wire logic [pot_status_pkg::ADDR_W-1:0]     CMD_ADDR_I,
  input  wire logic [pot_status_pkg::OP_W-1:0]       CMD_OP_I,
  input  wire logic                                  HV_PROG_VALID_I,
  input  wire logic [pot_status_pkg::HV_SEL_W-1:0]   HV_PROG_SEL_I,
  input  wire logic                                  HV_PROG_VAL_I,
  input  wire logic                                  WRITE_PROTECT_PIN_N_I,
  input  wire logic                                  NV_PROTECT_STORED_I,
  input  wire logic                                  NV_LOCK0_STORED_I,
  input  wire logic                                  NV_LOCK1_STORED_I,
  output logic                                       CMD_ACK_O,
  output logic                                       CMD_NAK_O,
  output logic [pot_status_pkg::DATA_W-1:0]          CMD_RDATA_O,
  output logic [pot_status_pkg::DATA_W-1:0]          TERMINAL_CONTROL_WMASK_O,
  output logic                                       NV_WRITE_START_O,
  output logic                                       NV_WRITE_ACTIVE_O,
  output logic                                       CH0_LOCK_O,
  output logic                                       CH1_LOCK_O,
  output logic                                       NV_PROTECT_O
);
  import pot_status_pkg::*;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_BUSY = 3'b100
  } ctrl_state_t;

  function automatic logic is_volatile(input logic [ADDR_W-1:0] a);
    return (a == ADDR_VWIPER0) || (a == ADDR_VWIPER1) || (a == ADDR_TERMINAL_CONTROL) || (a == ADDR_STATE);
  endfunction : is_volatile

  function automatic logic lock_hit(input logic [ADDR_W-1:0] a, input logic l0, input logic l1);
    return (l0 && ((a == ADDR_VWIPER0) || (a == ADDR_NVWIPER0))) ||
           (l1 && ((a == ADDR_VWIPER1) || (a == ADDR_NVWIPER1)));
  endfunction : lock_hit

  ctrl_state_t          state_ff;
  ctrl_state_t          nxt_state;
  logic                 ack_ff;
  logic                 nxt_ack;
  logic                 nak_ff;
  logic                 nxt_nak;
  logic [DATA_W-1:0]    rdata_ff;
  logic [DATA_W-1:0]    nxt_rdata;
  logic [DATA_W-1:0]    wmask_ff;
  logic [DATA_W-1:0]    nxt_wmask;
  logic                 start_ff;
  logic                 nxt_start;
  logic                 lock0_ff;
  logic                 nxt_lock0;
  logic                 lock1_ff;
  logic                 nxt_lock1;
  logic                 nvprot_ff;
  logic                 nxt_nvprot;
  logic                 protect_ff;
  logic                 nxt_protect;
  logic                 pend_hv_ff;
  logic                 nxt_pend_hv;
  logic [HV_SEL_W-1:0]  pend_sel_ff;
  logic [HV_SEL_W-1:0]  nxt_pend_sel;
  logic                 pend_val_ff;
  logic                 nxt_pend_val;
  logic                 timer_start;
  logic                 busy;
  logic                 timer_last;
  logic                 refuse;
  logic                 modify;
  logic [DATA_W-1:0]    state_word;

  nv_write_timer #(
    .CYCLES (NV_WRITE_CYCLES)
  ) u_timer (
    .clk_i   (CLK_SYS_I),
    .rst_i   (SYS_RST_I),
    .en_i    (CLK_EN_I),
    .start_i (timer_start),
    .busy_o  (busy),
    .last_o  (timer_last)
  );

  always_comb begin
    state_word                          = RST_DATA;
    state_word[DATA_W-1:ST_RSVD_LSB]    = ST_RSVD_ONES;
    state_word[ST_ACTIVE_BIT]           = busy;
    state_word[ST_LOCK1_BIT]            = lock1_ff;
    state_word[ST_LOCK0_BIT]            = lock0_ff;
    state_word[ST_PROT_BIT]             = protect_ff;
  end

  always_comb begin
    modify = CMD_OP_I != OP_READ;
    refuse = (busy && !is_volatile(CMD_ADDR_I)) ||
             (((CMD_OP_I == OP_INC) || (CMD_OP_I == OP_DEC)) &&
              (CMD_ADDR_I != ADDR_VWIPER0) && (CMD_ADDR_I != ADDR_VWIPER1)) ||
             (modify && lock_hit(CMD_ADDR_I, lock0_ff, lock1_ff)) ||
             ((CMD_OP_I == OP_WRITE) && !is_volatile(CMD_ADDR_I) && protect_ff);
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_ack      = 1'b0;
    nxt_nak      = 1'b0;
    nxt_rdata    = rdata_ff;
    nxt_wmask    = RST_DATA;
    nxt_start    = 1'b0;
    nxt_lock0    = lock0_ff;
    nxt_lock1    = lock1_ff;
    nxt_nvprot   = nvprot_ff;
    nxt_pend_hv  = pend_hv_ff;
    nxt_pend_sel = pend_sel_ff;
    nxt_pend_val = pend_val_ff;
    timer_start  = 1'b0;
    nxt_protect  = !WRITE_PROTECT_PIN_N_I || nvprot_ff;
    case (state_ff)
      ST_LOAD: begin
        // Stored copies are sampled once, after reset has been released
        nxt_lock0  = NV_LOCK0_STORED_I;
        nxt_lock1  = NV_LOCK1_STORED_I;
        nxt_nvprot = NV_PROTECT_STORED_I;
        nxt_nak    = CMD_VALID_I || HV_PROG_VALID_I;
        nxt_state  = ST_IDLE;
      end
      ST_IDLE, ST_BUSY: begin
        if (CMD_VALID_I) begin
          nxt_ack = !refuse;
          nxt_nak = refuse;
          if (!refuse && (CMD_OP_I == OP_READ)) begin
            // Only the status word is served here; other locations read as zero
            nxt_rdata = (CMD_ADDR_I == ADDR_STATE) ? state_word : RST_DATA;
          end
          if (!refuse && (CMD_OP_I == OP_WRITE) && (CMD_ADDR_I == ADDR_TERMINAL_CONTROL)) begin
            nxt_wmask                                = {1'b1, TERMINAL_CONTROL_CH_ALL, TERMINAL_CONTROL_CH_ALL};
            nxt_wmask[TERMINAL_CONTROL_CH1_LSB +: 4]             = lock1_ff ? TERMINAL_CONTROL_CH_NONE : TERMINAL_CONTROL_CH_ALL;
            nxt_wmask[TERMINAL_CONTROL_CH0_LSB +: 4]             = lock0_ff ? TERMINAL_CONTROL_CH_NONE : TERMINAL_CONTROL_CH_ALL;
          end
          // A write to the status word is acknowledged and has no effect
          if (!refuse && (CMD_OP_I == OP_WRITE) && !is_volatile(CMD_ADDR_I)) begin
            timer_start = 1'b1;
            nxt_start   = 1'b1;
            nxt_pend_hv = 1'b0;
            nxt_state   = ST_BUSY;
          end
        end else if (HV_PROG_VALID_I) begin
          nxt_ack = !busy;
          nxt_nak = busy;
          if (!busy) begin
            timer_start  = 1'b1;
            nxt_start    = 1'b1;
            nxt_pend_hv  = 1'b1;
            nxt_pend_sel = HV_PROG_SEL_I;
            nxt_pend_val = HV_PROG_VAL_I;
            nxt_state    = ST_BUSY;
          end
        end
        if (timer_last) begin
          nxt_state = ST_IDLE;
          if (pend_hv_ff) begin
            case (pend_sel_ff)
              HV_SEL_PROTECT: nxt_nvprot = pend_val_ff;
              HV_SEL_LOCK0:   nxt_lock0  = pend_val_ff;
              HV_SEL_LOCK1:   nxt_lock1  = pend_val_ff;
              default:        nxt_nvprot = nvprot_ff;
            endcase
          end
        end
      end
      default: begin
        nxt_state = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_ff    <= ST_LOAD;
      ack_ff      <= 1'b0;
      nak_ff      <= 1'b0;
      rdata_ff    <= RST_DATA;
      wmask_ff    <= RST_DATA;
      start_ff    <= 1'b0;
      lock0_ff    <= RST_LOCK;
      lock1_ff    <= RST_LOCK;
      nvprot_ff   <= RST_PROTECT;
      protect_ff  <= RST_PROTECT;
      pend_hv_ff  <= 1'b0;
      pend_sel_ff <= HV_SEL_PROTECT;
      pend_val_ff <= 1'b0;
    end else if (CLK_EN_I) begin
      state_ff    <= nxt_state;
      ack_ff      <= nxt_ack;
      nak_ff      <= nxt_nak;
      rdata_ff    <= nxt_rdata;
      wmask_ff    <= nxt_wmask;
      start_ff    <= nxt_start;
      lock0_ff    <= nxt_lock0;
      lock1_ff    <= nxt_lock1;
      nvprot_ff   <= nxt_nvprot;
      protect_ff  <= nxt_protect;
      pend_hv_ff  <= nxt_pend_hv;
      pend_sel_ff <= nxt_pend_sel;
      pend_val_ff <= nxt_pend_val;
    end
  end

  assign CMD_ACK_O         = ack_ff;
  assign CMD_NAK_O         = nak_ff;
  assign CMD_RDATA_O       = rdata_ff;
  assign TERMINAL_CONTROL_WMASK_O      = wmask_ff;
  assign NV_WRITE_START_O  = start_ff;
  assign NV_WRITE_ACTIVE_O = busy;
  assign CH0_LOCK_O        = lock0_ff;
  assign CH1_LOCK_O        = lock1_ff;
  assign NV_PROTECT_O      = protect_ff;

  // Checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  logic served;
  assign served = CLK_EN_I && CMD_VALID_I && (state_ff != ST_LOAD);

  a_reserved_ones: assert property (served && !refuse && (CMD_OP_I == OP_READ) && (CMD_ADDR_I == ADDR_STATE)
    |=> CMD_RDATA_O[8:4] == 5'h1F && CMD_RDATA_O[3] == $past(busy))
    else $error("status read lost reserved ones or write-active bit");
  a_active_follows: assert property (CLK_EN_I && NV_WRITE_START_O |-> NV_WRITE_ACTIVE_O)
    else $error("write started without write-active set");
  a_active_drops: assert property (CLK_EN_I && timer_last |=> !NV_WRITE_ACTIVE_O && state_ff == ST_IDLE)
    else $error("write-active did not drop when the timer ended");
  a_busy_refuse: assert property (served && busy && !is_volatile(CMD_ADDR_I) |=> CMD_NAK_O && !CMD_ACK_O)
    else $error("non-volatile location served during a write cycle");
  a_lock1_refuse: assert property (served && lock1_ff && modify &&
    ((CMD_ADDR_I == ADDR_VWIPER1) || (CMD_ADDR_I == ADDR_NVWIPER1)) |=> CMD_NAK_O)
    else $error("locked channel 1 wiper was modified");
  a_lock0_refuse: assert property (served && lock0_ff && modify &&
    ((CMD_ADDR_I == ADDR_VWIPER0) || (CMD_ADDR_I == ADDR_NVWIPER0)) |=> CMD_NAK_O)
    else $error("locked channel 0 wiper was modified");
  // Locks may move on the edge where a program retires, so compare with the locks seen at the request
  a_terminal_control_mask: assert property (served && (CMD_OP_I == OP_WRITE) && (CMD_ADDR_I == ADDR_TERMINAL_CONTROL)
    |=> TERMINAL_CONTROL_WMASK_O[8] && TERMINAL_CONTROL_WMASK_O[7:4] == ($past(lock1_ff) ? 4'h0 : 4'hF)
        && TERMINAL_CONTROL_WMASK_O[3:0] == ($past(lock0_ff) ? 4'h0 : 4'hF))
    else $error("terminal control mask ignores channel locks");
  a_protect_block: assert property (served && protect_ff && (CMD_OP_I == OP_WRITE) && !is_volatile(CMD_ADDR_I)
    |=> CMD_NAK_O && !NV_WRITE_START_O)
    else $error("non-volatile write passed while protected");
  a_volatile_open: assert property (served && protect_ff && !busy && !lock0_ff && (CMD_ADDR_I == ADDR_VWIPER0)
    && (CMD_OP_I != OP_READ) |=> CMD_ACK_O)
    else $error("volatile wiper 0 refused under protect");
  // The edge after reset sees reset values in the past, not a registered pin
  a_protect_or: assert property ($past(CLK_EN_I) && !$past(SYS_RST_I)
    |-> NV_PROTECT_O == $past(!WRITE_PROTECT_PIN_N_I || nvprot_ff))
    else $error("effective protect is not pin OR stored bit");
  a_state_ignore: assert property (served && !timer_last && (CMD_OP_I == OP_WRITE) && (CMD_ADDR_I == ADDR_STATE)
    |=> CMD_ACK_O && $stable(CH0_LOCK_O) && $stable(CH1_LOCK_O) && !NV_WRITE_START_O)
    else $error("status write changed state");
  a_nv_start: assert property (served && !refuse && (CMD_OP_I == OP_WRITE) && !is_volatile(CMD_ADDR_I)
    |=> NV_WRITE_START_O && NV_WRITE_ACTIVE_O)
    else $error("accepted non-volatile write did not start a write cycle");
  a_hv_busy: assert property (CLK_EN_I && (state_ff != ST_LOAD) && HV_PROG_VALID_I && !CMD_VALID_I && busy
    |=> CMD_NAK_O && !NV_WRITE_START_O)
    else $error("program request served during a write cycle");
  a_lock_load: assert property (CLK_EN_I && (state_ff == ST_LOAD)
    |=> CH0_LOCK_O == $past(NV_LOCK0_STORED_I) && CH1_LOCK_O == $past(NV_LOCK1_STORED_I))
    else $error("locks not loaded from stored copies after reset");
  // After the load state, locks move only when a high-voltage program retires, never on a serial write
  a_lock_hold: assert property (CLK_EN_I && !timer_last && (state_ff != ST_LOAD)
    |=> $stable(CH0_LOCK_O) && $stable(CH1_LOCK_O))
    else $error("lock mirror changed without a program cycle");
  a_rdata_other: assert property (served && !refuse && (CMD_OP_I == OP_READ) && (CMD_ADDR_I != ADDR_STATE)
    |=> CMD_RDATA_O == RST_DATA)
    else $error("location other than the status word returned data");

  // Scenarios the bench is expected to reach
  c_nv_write: cover property (served && !refuse && (CMD_OP_I == OP_WRITE) && !is_volatile(CMD_ADDR_I));
  c_hv_done: cover property (CLK_EN_I && timer_last && pend_hv_ff);
  c_busy_read: cover property (served && busy && (CMD_ADDR_I == ADDR_STATE) && (CMD_OP_I == OP_READ));
  c_lock_refuse: cover property (served && modify && lock_hit(CMD_ADDR_I, lock0_ff, lock1_ff));
  c_frozen_write: cover property (!CLK_EN_I && busy);

endmodule : pot_status_protect_logic

// >>> pot_host_model.sv
// Host-side command source facing the status and protect block
`timescale 1ns/10ps
module pot_host_model (
  input  wire logic                               clk_i,
  input  wire logic                               ack_i,
  input  wire logic                               nak_i,
  output logic                                    cmd_valid_o,
  output logic [pot_status_pkg::ADDR_W-1:0]       cmd_addr_o,
  output logic [pot_status_pkg::OP_W-1:0]         cmd_op_o,
  output logic                                    hv_valid_o,
  output logic [pot_status_pkg::HV_SEL_W-1:0]     hv_sel_o,
  output logic                                    hv_val_o
);
  import pot_status_pkg::*;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_addr_o  = 4'h0;
    cmd_op_o    = OP_READ;
    hv_valid_o  = 1'b0;
    hv_sel_o    = 2'h3;
    hv_val_o    = 1'b0;
  end

  // Released fields flip so a stale address can never look valid
  task automatic issue(input logic [ADDR_W-1:0] a, input logic [OP_W-1:0] o,
                       output logic ak, output logic nk);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_addr_o  <= a;
    cmd_op_o    <= o;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_addr_o  <= ~a;
    cmd_op_o    <= ~o;
    #1;
    while (!(ack_i || nak_i) && n < 3) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    ak = ack_i;
    nk = nak_i;
  endtask : issue

  // Apart from the reload from stored copies after reset, the stored protect bit and the locks change only through this request
  task automatic hv(input logic [HV_SEL_W-1:0] s, input logic v);
    @(posedge clk_i);
    hv_valid_o <= 1'b1;
    hv_sel_o   <= s;
    hv_val_o   <= v;
    @(posedge clk_i);
    hv_valid_o <= 1'b0;
    hv_sel_o   <= ~s;
    hv_val_o   <= ~v;
  endtask : hv
endmodule : pot_host_model

// >>> pot_status_protect_logic_tb.sv
// Self-checking bench for the status word and write gating
`timescale 1ns/10ps
module pot_status_protect_logic_tb;
  import pot_status_pkg::*;
  localparam int unsigned NVC = 8;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              wp_n    = 1'b1;
  logic              st_p    = 1'b0;
  logic              st_l0   = 1'b0;
  logic              st_l1   = 1'b1;
  logic              clk_en  = 1'b1;
  logic              cv, hvv, hvval, ack, nak, start, active, l0, l1, prot, ag, ng;
  logic [ADDR_W-1:0] ca;
  logic [OP_W-1:0]   co;
  logic [1:0]        hs;
  logic [DATA_W-1:0] rdata, wmask;
  int                failures = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                t0;

  always #2 clk_sys = ~clk_sys;

  pot_status_protect_logic #(.NV_WRITE_CYCLES(NVC)) pot_status_protect_logic_i (
    .CLK_SYS_I(clk_sys), .SYS_RST_I(sys_rst), .CLK_EN_I(clk_en),
    .CMD_VALID_I(cv), .CMD_ADDR_I(ca), .CMD_OP_I(co),
    .HV_PROG_VALID_I(hvv), .HV_PROG_SEL_I(hs), .HV_PROG_VAL_I(hvval),
    .WRITE_PROTECT_PIN_N_I(wp_n), .NV_PROTECT_STORED_I(st_p),
    .NV_LOCK0_STORED_I(st_l0), .NV_LOCK1_STORED_I(st_l1),
    .CMD_ACK_O(ack), .CMD_NAK_O(nak), .CMD_RDATA_O(rdata), .TERMINAL_CONTROL_WMASK_O(wmask),
    .NV_WRITE_START_O(start), .NV_WRITE_ACTIVE_O(active),
    .CH0_LOCK_O(l0), .CH1_LOCK_O(l1), .NV_PROTECT_O(prot));

  pot_host_model pot_host_model_i (
    .clk_i(clk_sys), .ack_i(ack), .nak_i(nak), .cmd_valid_o(cv), .cmd_addr_o(ca),
    .cmd_op_o(co), .hv_valid_o(hvv), .hv_sel_o(hs), .hv_val_o(hvval));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // Generous ceiling: the whole sequence needs about 130 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk

  function automatic logic [8:0] st(input logic a, input logic w1, input logic w0, input logic p);
    return {5'h1F, a, w1, w0, p};
  endfunction : st

  task automatic cmd(input logic [3:0] a, input logic [1:0] o, input logic e);
    pot_host_model_i.issue(a, o, ag, ng);
    chk("ack", {8'h00, e}, {8'h00, ag});
    chk("nak", {8'h00, ~e}, {8'h00, ng});
  endtask : cmd

  task automatic wait_idle();
    int n;
    n = 0;
    while (active !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("idle", 9'h000, {8'h00, active});
  endtask : wait_idle

  // Programming finishes one cycle before effective protect follows it
  task automatic hvp(input logic [1:0] s, input logic v);
    pot_host_model_i.hv(s, v);
    #1;
    chk("hv active", 9'h001, {8'h00, active});
    chk("hv ack", 9'h001, {8'h00, ack});
    wait_idle();
    @(posedge clk_sys);
    #1;
  endtask : hvp

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("locks", 9'h002, {7'h00, l1, l0});
    cmd(ADDR_STATE, OP_READ, 1'b1);
    chk("status", st(0, 1, 0, 0), rdata);
    cmd(ADDR_VWIPER1, OP_WRITE, 1'b0);
    cmd(ADDR_NVWIPER1, OP_WRITE, 1'b0);
    cmd(ADDR_VWIPER1, OP_INC, 1'b0);
    cmd(ADDR_VWIPER0, OP_DEC, 1'b1);
    cmd(ADDR_TERMINAL_CONTROL, OP_WRITE, 1'b1);
    chk("mask", 9'h10F, wmask);
    cmd(ADDR_STATE, OP_WRITE, 1'b1);
    cmd(ADDR_STATE, OP_READ, 1'b1);
    chk("status", st(0, 1, 0, 0), rdata);
    hvp(HV_SEL_LOCK1, 1'b0);
    hvp(HV_SEL_LOCK0, 1'b1);
    chk("locks", 9'h001, {7'h00, l1, l0});
    cmd(ADDR_STATE, OP_READ, 1'b1);
    chk("status", st(0, 0, 1, 0), rdata);
    cmd(ADDR_VWIPER0, OP_WRITE, 1'b0);
    cmd(ADDR_NVWIPER0, OP_WRITE, 1'b0);
    cmd(ADDR_VWIPER0, OP_INC, 1'b0);
    cmd(ADDR_VWIPER1, OP_WRITE, 1'b1);
    cmd(ADDR_TERMINAL_CONTROL, OP_WRITE, 1'b1);
    chk("mask", 9'h1F0, wmask);
    @(posedge clk_sys);
    wp_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("protect pin", 9'h001, {8'h00, prot});
    cmd(4'h6, OP_WRITE, 1'b0);
    cmd(ADDR_NVWIPER1, OP_WRITE, 1'b0);
    cmd(ADDR_VWIPER1, OP_WRITE, 1'b1);
    cmd(ADDR_VWIPER1, OP_INC, 1'b1);
    cmd(ADDR_VWIPER1, OP_DEC, 1'b1);
    cmd(ADDR_TERMINAL_CONTROL, OP_WRITE, 1'b1);
    cmd(ADDR_NVWIPER0, OP_READ, 1'b1);
    chk("other read", 9'h000, rdata);
    cmd(ADDR_STATE, OP_READ, 1'b1);
    chk("status", st(0, 0, 1, 1), rdata);
    @(posedge clk_sys);
    wp_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("protect off", 9'h000, {8'h00, prot});
    hvp(HV_SEL_PROTECT, 1'b1);
    chk("protect stored", 9'h001, {8'h00, prot});
    cmd(4'hF, OP_WRITE, 1'b0);
    hvp(HV_SEL_PROTECT, 1'b0);
    chk("protect clear", 9'h000, {8'h00, prot});
    cmd(4'h6, OP_WRITE, 1'b1);
    t0 = cyc;
    chk("start", 9'h003, {7'h00, start, active});
    cmd(ADDR_NVWIPER1, OP_WRITE, 1'b0);
    cmd(ADDR_STATE, OP_READ, 1'b1);
    chk("status", st(1, 0, 1, 0), rdata);
    cmd(ADDR_VWIPER1, OP_INC, 1'b1);
    pot_host_model_i.hv(HV_SEL_PROTECT, 1'b1);
    #1;
    chk("hv nak", 9'h001, {8'h00, nak});
    wait_idle();
    chk("write time", NVC[8:0], 9'(cyc - t0));
    cmd(4'h7, OP_WRITE, 1'b1);
    t0 = cyc;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    clk_en <= 1'b1;
    wait_idle();
    chk("frozen write time", 9'(NVC + 4), 9'(cyc - t0));
    cmd(ADDR_STATE, OP_READ, 1'b1);
    chk("status", st(0, 0, 1, 0), rdata);
    @(posedge clk_sys);
    st_l0   <= 1'b0;
    st_l1   <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("locks reload", 9'h002, {7'h00, l1, l0});
    complete_run();
  end
endmodule : pot_status_protect_logic_tb
